/* src/rx_address_filter_wakeup.v */
/*
 Receive destination address filter with four wake-up frame filters.
 Assumes a MAC receive byte stream synchronous to clk_i: one byte per
 rx_valid_i, rx_sof_i on the first destination byte, rx_eof_i on the last
 byte of the frame. Registers are reached over classic Wishbone.
*/
// Overview of operation
// - First destination bit tells individual from multicast address.
// - Frames failing the selected filter mode are not accepted.
// - All mode bits clear: every address checked by exact station match.
// - Hash-multicast only: individual exact, multicast through hash table.
// - Hash-all with hash-multicast: every address through hash table.
// - Inverse only: accept non-matching, reject station-matching frames.
// - Accept-everything with inverse clear passes all frames, broadcasts too.
// - Pass-all-multicast accepts multicast; individual exact or hashed.
// - Exact match uses full field against joined station registers.
// - CRC of destination, top six bits index 64-bit hash table.
// - Index top bit picks high or low word, rest picks bit.
// - Wake enable suspends reception and runs wake pattern checking.
// - Wake match sets received flag, signals irq or power event.
// - Clearing wake enable in full power returns the block to normal reception.
// - Four filters; frames passing the address mode, type and CRC are wake frames.
// - Mask bits 30..0 select bytes offset plus j; bit 31 zero.
// - Command bit 3 picks multicast or unicast; bits 2..1 reserved.
// - Command bit 0 enables the filter.
// - Offset must exceed 12 so address bytes stay out of CRC.
// - Full power follows enable; low power keeps wake detection always on.
// - Offset in bits 7..0 counts from first destination byte.
// - Filter CRC-16 compared with CRC over masked bytes.
`default_nettype none
`include "rx_filter_map.vh"

module rx_address_filter_wakeup (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire        rx_valid_i,
   input  wire [7:0]  rx_data_i,
   input  wire        rx_sof_i,
   input  wire        rx_eof_i,
   input  wire        low_power_i,
   output reg         frame_accept_o,
   output reg         frame_reject_o,
   output reg         wake_detect_o,
   output reg         wake_irq_o,
   output reg         power_event_output_o
);

   // =======================================================================
   // CRC helpers, bit-serial over one byte, least significant bit first
   // Left-shifting engines, data bits fed LSB first,
   // no final inversion. Hash and wake patterns share
   // this bit order; software must mirror it when it
   // works out table bits and pattern CRC words.
   function [31:0] crc32_byte;
      input [31:0] c;
      input [7:0]  d;
      integer      k;
      reg   [31:0] r;
      begin
         r = c;
         for (k = 0; k < 8; k = k + 1) begin
            if (r[31] ^ d[k])
               r = {r[30:0], 1'b0} ^ `CRC32_POLY;
            else
               r = {r[30:0], 1'b0};
         end
         crc32_byte = r;
      end
   endfunction

   function [15:0] crc16_byte;
      input [15:0] c;
      input [7:0]  d;
      integer      k;
      reg   [15:0] r;
      begin
         r = c;
         for (k = 0; k < 8; k = k + 1) begin
            if (r[15] ^ d[k])
               r = {r[14:0], 1'b0} ^ `CRC16_POLY;
            else
               r = {r[14:0], 1'b0};
         end
         crc16_byte = r;
      end
   endfunction

   // Byte-lane merge for Wishbone writes
   // Unselected lanes keep their byte, so software
   // can update part of a register without a read.
   function [31:0] lane_merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  sel;
      integer      k;
      begin
         lane_merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (sel[k])
               lane_merge[8*k +: 8] = nw[8*k +: 8];
         end
      end
   endfunction

   // =======================================================================
   // Register state
   // The port words sit in one array; the pointer
   // picks the word the next port access touches.
   reg  [4:0]  control_q;
   reg  [15:0] station_high_q;
   reg  [31:0] station_low_q;
   reg  [31:0] hash_high_q;
   reg  [31:0] hash_low_q;
   reg  [31:0] wake_word_q [0:`WAKE_WORDS-1];
   reg  [2:0]  wake_ptr_q;
   reg         wake_en_q;
   reg         wake_flag_q;
   reg         wake_irq_en_q;
   reg         wake_pme_en_q;
   integer     w;

   // A held strobe is taken once: requests count
   // only while ack is low.
   wire        bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        bus_wr    = bus_req & wb_we_i;
   wire        port_hit  = (wb_adr_i == `ADR_WAKE_PORT);
   wire        ctrl_hit  = (wb_adr_i == `ADR_WAKE_CTRL);
   wire        wake_hit_ev;
   // Low power state forces wake detection on, whatever software set
   // Clearing the enable in full power resumes reception
   wire        wake_active = wake_en_q | low_power_i;
   // Upper half of the merged word has no storage behind it
   wire [31:0] station_high_merged = lane_merge({16'h0, station_high_q}, wb_dat_i, wb_sel_i);

   // Write mask per port word keeps reserved bits at zero
   // Reserved bits are dropped on the way in, so
   // they always read back as zero.
   reg  [31:0] port_mask;
   always @* begin
      if (wake_ptr_q < `WAKE_CMD_WORD)
         port_mask = `MASK_WRITE_MASK;
      else if (wake_ptr_q == `WAKE_CMD_WORD)
         port_mask = `CMD_WRITE_MASK;
      else
         port_mask = 32'hffff_ffff;
   end

   // =======================================================================
   // Wishbone slave: ack one cycle after the strobe, dropped the next cycle
   // Unmapped addresses read zero, writes ignored.
   // The port pointer also moves on reads, so a
   // driver that reads the port must count those
   // accesses or the next load hits the wrong word.
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o       <= 1'b0;
         wb_dat_o       <= `RST_WORD;
         control_q      <= `RST_CONTROL;
         station_high_q <= 16'h0000;
         station_low_q  <= `RST_WORD;
         hash_high_q    <= `RST_WORD;
         hash_low_q     <= `RST_WORD;
         wake_ptr_q     <= 3'h0;
         wake_en_q      <= 1'b0;
         wake_irq_en_q  <= 1'b0;
         wake_pme_en_q  <= 1'b0;
         for (w = 0; w < `WAKE_WORDS; w = w + 1)
            wake_word_q[w] <= `RST_WORD;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req) begin
            case (wb_adr_i)
               `ADR_MAC_CONTROL:  wb_dat_o <= {27'h0, control_q};
               `ADR_STATION_HIGH: wb_dat_o <= {16'h0, station_high_q};
               `ADR_STATION_LOW:  wb_dat_o <= station_low_q;
               `ADR_HASH_HIGH:    wb_dat_o <= hash_high_q;
               `ADR_HASH_LOW:     wb_dat_o <= hash_low_q;
               `ADR_WAKE_PORT:    wb_dat_o <= wake_word_q[wake_ptr_q];
               `ADR_WAKE_CTRL:    wb_dat_o <= {28'h0, wake_pme_en_q, wake_irq_en_q, wake_flag_q, wake_en_q};
               default:           wb_dat_o <= `RST_WORD;
            endcase
         end
         // Each port access steps to the next word, wrapping after eight
         if (bus_req && port_hit)
            wake_ptr_q <= wake_ptr_q + 3'h1;
         if (bus_wr) begin
            case (wb_adr_i)
               `ADR_MAC_CONTROL: begin
                  if (wb_sel_i[0])
                     control_q <= wb_dat_i[4:0];
               end
               `ADR_STATION_HIGH: station_high_q <= station_high_merged[15:0];
               `ADR_STATION_LOW:  station_low_q  <= lane_merge(station_low_q, wb_dat_i, wb_sel_i);
               `ADR_HASH_HIGH:    hash_high_q    <= lane_merge(hash_high_q, wb_dat_i, wb_sel_i);
               `ADR_HASH_LOW:     hash_low_q     <= lane_merge(hash_low_q, wb_dat_i, wb_sel_i);
               `ADR_WAKE_PORT: begin
                  wake_word_q[wake_ptr_q] <= lane_merge(wake_word_q[wake_ptr_q], wb_dat_i, wb_sel_i)
                                             & port_mask;
               end
               `ADR_WAKE_CTRL: begin
                  if (wb_sel_i[0]) begin
                     wake_en_q     <= wb_dat_i[`BIT_WAKE_EN];
                     wake_irq_en_q <= wb_dat_i[`BIT_WAKE_IRQ_EN];
                     wake_pme_en_q <= wb_dat_i[`BIT_WAKE_PME_EN];
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Received flag: hardware set wins over a write-one clear
   // A wake frame ending in the cycle of a clear
   // keeps the flag set, so no event is lost.
   always @(posedge clk_i) begin
      if (rst_i)
         wake_flag_q <= 1'b0;
      else if (wake_hit_ev)
         wake_flag_q <= 1'b1;
      else if (bus_wr && ctrl_hit && wb_sel_i[0] && wb_dat_i[`BIT_WAKE_FLAG])
         wake_flag_q <= 1'b0;
   end

   // =======================================================================
   // Receive byte tracking
   // Index zero is the start-of-frame byte; idle
   // cycles do not advance it. The first six bytes
   // are kept for the address check at frame end.
   // Frames over 2047 bytes pin the index there.
   reg  [10:0] cnt_q;
   reg  [47:0] da_q;
   wire [10:0] byte_idx = rx_sof_i ? 11'h000 : cnt_q;
   wire        eof_ev   = rx_valid_i & rx_eof_i;

   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= 11'h000;
         da_q  <= 48'h0;
      end else if (rx_valid_i) begin
         // Counter saturates so overlong frames cannot wrap into the window
         if (byte_idx != `BYTE_CNT_MAX)
            cnt_q <= byte_idx + 11'h001;
         else
            cnt_q <= byte_idx;
         if (byte_idx < `DA_BYTES)
            da_q[{byte_idx[2:0], 3'b000} +: 8] <= rx_data_i;
      end
   end

   // =======================================================================
   // Address check
   // Long combinational path, but it only has to
   // settle once per frame, at the last byte.
   reg  [31:0] hash_crc;
   integer     b;
   always @* begin
      hash_crc = `CRC32_INIT;
      for (b = 0; b < 6; b = b + 1)
         hash_crc = crc32_byte(hash_crc, da_q[8*b +: 8]);
   end

   wire        is_mcast  = da_q[0];
   wire        exact     = (da_q == {station_high_q, station_low_q});
   wire [5:0]  hash_idx  = hash_crc[31:26];
   wire        hash_hit  = hash_idx[5] ? hash_high_q[hash_idx[4:0]]
                                       : hash_low_q[hash_idx[4:0]];
   wire        m_hmc     = control_q[`BIT_HASH_MCAST];
   wire        m_hall    = control_q[`BIT_HASH_ALL];
   wire        m_inv     = control_q[`BIT_INVERSE];
   wire        m_all     = control_q[`BIT_ACCEPT_ALL];
   wire        m_pmc     = control_q[`BIT_PASS_MCAST];
   wire        full_da   = (byte_idx >= `DA_BYTES);
   reg         addr_ok;

   // Mode priority: inverse, promiscuous, then multicast and individual paths
   // Unlisted combinations follow this order, so
   // every setting of the five bits has one answer.
   always @* begin
      if (m_all && !m_inv)
         addr_ok = 1'b1;
      else if (m_inv)
         addr_ok = !exact;
      else if (is_mcast) begin
         if (m_pmc)
            addr_ok = 1'b1;
         else if (m_hmc)
            addr_ok = hash_hit;
         else
            addr_ok = exact;
      end else begin
         if (m_hall && m_hmc)
            addr_ok = hash_hit;
         else
            addr_ok = exact;
      end
   end

   // =======================================================================
   // Wake filters, one CRC-16 engine each
   // Four engines see every byte, so all filters
   // judge one frame in parallel. The compare uses
   // crc_d, which already holds the last byte when
   // that byte falls inside the mask window.
   wire [3:0]  filt_hit;
   genvar      g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : filt
         wire [30:0] mask    = wake_word_q[g][30:0];
         wire [3:0]  cmd     = wake_word_q[`WAKE_CMD_WORD][8*g +: 4];
         wire [7:0]  off     = wake_word_q[`WAKE_OFF_WORD][8*g +: 8];
         wire [15:0] exp_crc = wake_word_q[`WAKE_CRC_WORD + g/2][16*(g%2) +: 16];
         wire [10:0] rel     = byte_idx - {3'h0, off};
         wire        in_win  = (byte_idx >= {3'h0, off}) && (rel < `WAKE_MASK_BITS)
                               && mask[rel[4:0]];
         reg  [15:0] crc_q;
         // Start of frame reseeds the engine
         wire [15:0] base    = rx_sof_i ? `CRC16_INIT : crc_q;
         wire [15:0] crc_d   = in_win ? crc16_byte(base, rx_data_i) : base;
         always @(posedge clk_i) begin
            if (rst_i)
               crc_q <= `CRC16_INIT;
            else if (rx_valid_i)
               crc_q <= crc_d;
         end
         // Low offsets would fold address bytes in, so such a filter never hits
         assign filt_hit[g] = cmd[0]
                              && (off > `WAKE_MIN_OFFSET)
                              && (cmd[3] == is_mcast)
                              && (crc_d == exp_crc);
      end
   endgenerate

   // Wake frame needs a frame passing the address mode plus one enabled filter match
   // A frame the current mode would drop can never
   // wake the host, whatever its pattern.
   assign wake_hit_ev = eof_ev && wake_active && full_da && addr_ok
                        && (|filt_hit);

   // =======================================================================
   // Frame verdict and host signalling, all registered
   // Verdicts pulse one cycle after the last byte.
   // Interrupt and power event are levels that hold
   // until the flag or its enable is cleared.
   always @(posedge clk_i) begin
      if (rst_i) begin
         frame_accept_o       <= 1'b0;
         frame_reject_o       <= 1'b0;
         wake_detect_o        <= 1'b0;
         wake_irq_o           <= 1'b0;
         power_event_output_o <= 1'b0;
      end else begin
         // Normal path closed while wake detection runs
         frame_accept_o       <= eof_ev && !wake_active && full_da && addr_ok;
         frame_reject_o       <= eof_ev && (wake_active || !full_da || !addr_ok);
         wake_detect_o        <= wake_hit_ev;
         wake_irq_o           <= (wake_flag_q | wake_hit_ev) & wake_irq_en_q;
         power_event_output_o <= (wake_flag_q | wake_hit_ev) & wake_pme_en_q;
      end
   end

endmodule // rx_address_filter_wakeup
`default_nettype wire

/* src/rx_filter_map.vh */
/*
 Register offsets, field positions, reset values and CRC constants of the
 receive address filter with wake-up frame detection.
 Assumes inclusion by its bare name from the design file and the bench.
*/
`ifndef RX_FILTER_MAP_VH
`define RX_FILTER_MAP_VH

// ==========================================================================
// Register byte addresses (word aligned)
`define ADR_MAC_CONTROL   8'h00
`define ADR_STATION_HIGH  8'h04
`define ADR_STATION_LOW   8'h08
`define ADR_HASH_HIGH     8'h0c
`define ADR_HASH_LOW      8'h10
`define ADR_WAKE_PORT     8'h14
`define ADR_WAKE_CTRL     8'h18

// ==========================================================================
// Control register field positions
`define BIT_HASH_MCAST    0
`define BIT_HASH_ALL      1
`define BIT_INVERSE       2
`define BIT_ACCEPT_ALL    3
`define BIT_PASS_MCAST    4
`define BIT_WAKE_EN       0
`define BIT_WAKE_FLAG     1
`define BIT_WAKE_IRQ_EN   2
`define BIT_WAKE_PME_EN   3

// ==========================================================================
// Reset values
`define RST_CONTROL       5'h00
`define RST_WORD          32'h0000_0000
`define RST_WAKE_CTRL     4'h0

// ==========================================================================
// Wake filter port layout and limits
`define WAKE_WORDS        8
`define WAKE_CMD_WORD     4
`define WAKE_OFF_WORD     5
`define WAKE_CRC_WORD     6
`define WAKE_MASK_BITS    11'd31
`define WAKE_MIN_OFFSET   8'd12
`define CMD_WRITE_MASK    32'h0909_0909
`define MASK_WRITE_MASK   32'h7fff_ffff

// ==========================================================================
// CRC constants and frame byte limits
`define CRC32_POLY        32'h04c1_1db7
`define CRC32_INIT        32'hffff_ffff
`define CRC16_POLY        16'h8005
`define CRC16_INIT        16'hffff
`define BYTE_CNT_MAX      11'h7ff
`define DA_BYTES          11'd6

`endif

/* verif/rx_filter_checker_assertions.sv */
/* Checker for the receive address filter: bus handshake and frame verdict timing.
   Assumes it is bound to rx_address_filter_wakeup and sees only that module's ports. */
`default_nettype none
module rx_filter_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic rx_valid_i,
   input wire logic rx_eof_i,
   input wire logic frame_accept_o,
   input wire logic frame_reject_o,
   input wire logic wake_detect_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========================================================================
   // Steps of a bus access and of a frame end
   sequence bus_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence frame_end;
      rx_valid_i && rx_eof_i;
   endsequence
   sequence one_verdict;
      frame_accept_o ^ frame_reject_o;
   endsequence
   // ==========================================================================
   // Assertions
   a_ack_prompt: assert property (bus_req |=> wb_ack_o) else $error("ack missing after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   a_verdict_prompt: assert property (frame_end |=> one_verdict) else $error("no single verdict after frame end");
   a_verdict_cause: assert property ((frame_accept_o || frame_reject_o || wake_detect_o)
      |-> $past(rx_valid_i && rx_eof_i)) else $error("verdict without frame end");
   a_verdict_excl: assert property (!(frame_accept_o && frame_reject_o)) else $error("accept and reject together");
   a_wake_blocks: assert property (wake_detect_o |-> frame_reject_o) else $error("wake frame not held back");
   a_accept_once: assert property (frame_accept_o |=> !frame_accept_o) else $error("accept longer than one cycle");
   c_wake_seen: cover property (wake_detect_o);
endmodule // rx_filter_checker
bind rx_address_filter_wakeup rx_filter_checker chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rx_valid_i,
   .rx_eof_i, .frame_accept_o, .frame_reject_o, .wake_detect_o);
`default_nettype wire

/* verif/rx_stream_model.sv */
/* Model of the MAC receive datapath feeding the filter at most one byte per cycle.
   Assumes the bench fills frame_mem and calls send from a single process. */
`default_nettype none
module rx_stream_model (
   input  wire logic       clk_i,
   output logic            rx_valid_o,
   output logic [7:0]      rx_data_o,
   output logic            rx_sof_o,
   output logic            rx_eof_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] frame_mem [0:63];
   int         seed = 94195;
   initial begin
      rx_valid_o = 1'b0;
      rx_data_o  = 8'h5a;
      rx_sof_o   = 1'b0;
      rx_eof_o   = 1'b0;
   end
   // ==========================================================================
   // Frame sender: random idle gaps; data toggles while idle so a stale byte never passes for a fresh one
   task automatic send(input int len);
      for (int i = 0; i < len; i++) begin
         if ($random(seed) % 4 == 0) begin
            @(posedge clk_i);
            rx_valid_o <= 1'b0;
            rx_data_o  <= ~rx_data_o;
         end
         @(posedge clk_i);
         rx_valid_o <= 1'b1;
         rx_data_o  <= frame_mem[i];
         rx_sof_o   <= (i == 0);
         rx_eof_o   <= (i == len - 1);
      end
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_sof_o   <= 1'b0;
      rx_eof_o   <= 1'b0;
      rx_data_o  <= ~rx_data_o;
   endtask
endmodule // rx_stream_model
`default_nettype wire

/* verif/test_rx_address_filter_wakeup.sv */
/* Bench for the receive address filter: registers over Wishbone, random frames in every
   listed mode, four wake-up filters. Assumes the design header on the include path. */
`default_nettype none
`include "rx_filter_map.vh"
module test_rx_address_filter_wakeup;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, low_power_i = 0;
   logic [7:0]  wb_adr_i = 0;
   logic [31:0] wb_dat_i = 0, hash_hi, hash_lo;
   logic [47:0] sta;
   wire  [31:0] wb_dat_o;
   wire  [7:0]  rx_data_i;
   wire         wb_ack_o, rx_valid_i, rx_sof_i, rx_eof_i, frame_accept_o, frame_reject_o;
   wire         wake_detect_o, wake_irq_o, power_event_output_o;
   int          errors = 0, n_compared = 0, seed = 94195, cycles = 0;
   logic [4:0]  modes [9] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h08, 5'h1b, 5'h10, 5'h11, 5'h13};
   logic [7:0]  regs [7] = '{`ADR_MAC_CONTROL, `ADR_STATION_HIGH, `ADR_STATION_LOW, `ADR_HASH_HIGH,
                             `ADR_HASH_LOW, `ADR_WAKE_CTRL, 8'h1c};
   // Wake cases: offset, command byte, multicast frame, low power, wake expected
   int          wt [5][5] = '{'{14, 1, 0, 0, 1}, '{12, 1, 0, 0, 0}, '{20, 9, 1, 1, 1}, '{15, 8, 1, 0, 0},
                              '{16, 9, 0, 0, 0}};
   rx_address_filter_wakeup DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf),
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_valid_i, .rx_data_i, .rx_sof_i, .rx_eof_i, .low_power_i,
      .frame_accept_o, .frame_reject_o, .wake_detect_o, .wake_irq_o, .power_event_output_o);
   rx_stream_model src (.clk_i, .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_sof_o(rx_sof_i),
      .rx_eof_o(rx_eof_i));
   // ==========================================================================
   // Clock, hang guard and reporting
   initial forever #2 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         $display("[FAIL] run length expected below %0d seen %0d", 20000, cycles);
         finish_test();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("Compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ==========================================================================
   // Wishbone master: request held until ack is sampled, then released for a cycle
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      r = wb_dat_o;
      check("bus ack", wb_ack_o, 1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      check($sformatf("reg %h", a), x & msk, exp);
   endtask
   // ==========================================================================
   // Reference: bitwise CRC, LSB of each byte first, and the filter verdict
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d, input int w);
      logic [31:0] p;
      p = (w == 32) ? `CRC32_POLY : {16'h0000, `CRC16_POLY};
      for (int i = 0; i < 8; i++) c = ((c << 1) ^ ((c[w-1] ^ d[i]) ? p : 32'h0)) & (w == 32 ? 32'hffffffff : 32'hffff);
      return c;
   endfunction
   function automatic logic exp_accept(input logic [4:0] m, input int len);
      logic [31:0] h;
      logic        ex, hs, mc;
      h = `CRC32_INIT;
      for (int i = 0; i < 6; i++) h = crc_byte(h, src.frame_mem[i], 32);
      hs = h[31] ? hash_hi[h[30:26]] : hash_lo[h[30:26]];
      ex = {src.frame_mem[5], src.frame_mem[4], src.frame_mem[3], src.frame_mem[2], src.frame_mem[1],
            src.frame_mem[0]} == sta;
      mc = src.frame_mem[0][0];
      if (len < 7) return 1'b0;
      if (m[3] && !m[2]) return 1'b1;
      if (m[2]) return !ex;
      if (mc) return m[4] || (m[0] ? hs : ex);
      return (m[1] && m[0]) ? hs : ex;
   endfunction
   // Frame kinds: 0 station, 1 random, 2 broadcast, 3 near miss, 4 multicast
   task automatic fill(input int kind);
      for (int i = 0; i < 64; i++) src.frame_mem[i] = 8'($random(seed));
      for (int i = 0; i < 6; i++) begin
         if (kind == 0 || kind == 3) src.frame_mem[i] = sta[8*i +: 8];
         if (kind == 2) src.frame_mem[i] = 8'hff;
      end
      if (kind == 3) src.frame_mem[5] ^= 8'h80;
      if (kind == 4) src.frame_mem[0] = 8'h01;
   endtask
   // ==========================================================================
   // Main sequence
   initial begin
      logic [31:0] x, msk, c16;
      logic [4:0]  m;
      int          len, k;
      logic        e;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (regs[a]) rd(regs[a], `RST_WORD, 32'hffffffff);
      wr(8'h1c, 32'hdead_beef);
      rd(8'h1c, 32'h0, 32'hffffffff);
      sta = {16'($random(seed)), 32'($random(seed))} & 48'hffff_ffff_fffe;
      hash_hi = $random(seed);
      hash_lo = $random(seed);
      wr(`ADR_STATION_HIGH, {16'h0, sta[47:32]});
      wr(`ADR_STATION_LOW, sta[31:0]);
      wr(`ADR_HASH_HIGH, hash_hi);
      wr(`ADR_HASH_LOW, hash_lo);
      rd(`ADR_STATION_HIGH, {16'h0, sta[47:32]}, 32'hffff);
      rd(`ADR_HASH_LOW, hash_lo, 32'hffffffff);
      for (int f = 0; f < 72; f++) begin
         m = modes[f % 9];
         len = (f % 10 == 9) ? 6 : 7 + $unsigned($random(seed)) % 14;
         fill($unsigned($random(seed)) % 4);
         wr(`ADR_MAC_CONTROL, {27'h0, m});
         src.send(len);
         #1;
         e = exp_accept(m, len);
         check("accept", frame_accept_o, e);
         check("reject", frame_reject_o, !e);
      end
      wr(`ADR_MAC_CONTROL, 32'h10);
      for (int i = 0; i < 5; i++) begin
         k = i % 4;
         e = (wt[i][4] != 0);
         fill(wt[i][2] ? 4 : 0);
         msk = ($random(seed) & `MASK_WRITE_MASK) | 32'h1;
         c16 = {16'h0, `CRC16_INIT};
         for (int j = 0; j < 31; j++) if (msk[j]) c16 = crc_byte(c16, src.frame_mem[wt[i][0] + j], 16);
         for (int w = 0; w < `WAKE_WORDS; w++) begin
            x = w < 4 ? (w == k ? msk : 0) : w == 4 ? wt[i][1] << 8 * k : w == 5 ? wt[i][0] << 8 * k :
                (w - 6 == k / 2 ? c16 << 16 * (k % 2) : 0);
            wr(`ADR_WAKE_PORT, x);
         end
         wr(`ADR_WAKE_CTRL, wt[i][3] ? 32'hc : 32'hd);
         low_power_i <= (wt[i][3] != 0);
         src.send(52);
         #1;
         check("wake", wake_detect_o, e);
         check("wake accept", frame_accept_o, 0);
         check("wake reject", frame_reject_o, 1);
         @(posedge clk_i);
         #1;
         check("irq", wake_irq_o, e);
         check("pme", power_event_output_o, e);
         rd(`ADR_WAKE_CTRL, (wt[i][3] ? 32'hc : 32'hd) | (e << 1), 32'hf);
         wr(`ADR_WAKE_CTRL, 32'h2);
         low_power_i <= 1'b0;
         rd(`ADR_WAKE_CTRL, 32'h0, 32'hf);
         src.send(52);
         #1;
         check("resume", frame_accept_o, 1);
      end
      finish_test();
   end
endmodule // test_rx_address_filter_wakeup
`default_nettype wire
